// ===== rtl/rsb_reset_strap_boot_select.v
// Reset strap capture and boot path selection
`timescale 1ns/1ns
`include "rsb_defs.vh"

// Functional notes
// - Capture all straps at power-on reset release, then apply captured values.
// - Boot code 00 host no PLL, 01 two-wire, 10 host with PLL, 11 reserved.
// - Captured watchdog strap 1 enables watchdog, 0 leaves it disabled.
// - Strobe polarity strap 1 gives active-high strobes, 0 active-low.
// - Width strap 1 gives 8-bit host port, 0 gives 16-bit.
// - Host port straps captured only at power-on release; hard reset keeps them.
// - After power-on reset bypass PLL, run from input clock until software enables.
// - Start in ROM boot loader; PLL enable allowed only after initialization.
// - Host-port boot runs without DMA and with polled transfers on both sides.
// - Host port bit 0 is the least significant bit.
// - Two-wire boot muxes shared pins to two-wire and acts as bus master.
module rsb_reset_strap_boot_select
(
    input  wire       clock,
    input  wire       arst_n,
    input  wire       power_on_reset_n,
    input  wire       hard_reset_n_in,
    input  wire       hard_reset_req,
    input  wire [1:0] boot_source_strap,
    input  wire       watchdog_enable_strap,
    input  wire       host_strobe_polarity_strap,
    input  wire       host_width_strap,
    input  wire       host_strobe_style_strap,
    input  wire       sw_pll_enable,
    input  wire       boot_complete,
    output reg        hard_reset_n_out,
    output reg        hard_reset_n_oe,
    output reg  [1:0] boot_source,
    output reg        watchdog_enable,
    output reg        host_strobe_active_high,
    output reg        host_width_8bit,
    output reg        host_strobe_style,
    output reg        pll_bypass,
    output reg        pll_enable,
    output reg        rom_loader_run,
    output reg        host_boot_active,
    output reg        host_dma_enable,
    output reg        host_irq_enable,
    output reg        host_msw_first,
    output reg        host_bit0_lsb,
    output reg        two_wire_pin_select,
    output reg        two_wire_master,
    output reg        boot_reserved_error
);

    // Synchronised pin levels
    wire       por_n;
    wire       hrst_n;
    wire [1:0] boot_sync;
    wire       wdog_sync;
    wire       polarity_sync;
    wire       width_sync;
    wire       style_sync;
    reg        por_prev_r;
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [3:0] rom_cnt_r;
    reg  [3:0] rom_cnt_nxt;

    wire por_rise   = por_n & ~por_prev_r;
    wire in_reset   = ~por_n | ~hrst_n;

    // Two flops on every pin from outside the clock domain
    rsb_sync #(.WIDTH (1)) por_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (power_on_reset_n),
        .level  (por_n)
    );

    rsb_sync #(.WIDTH (1)) hrst_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (hard_reset_n_in),
        .level  (hrst_n)
    );

    rsb_sync #(.WIDTH (2)) boot_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (boot_source_strap),
        .level  (boot_sync)
    );

    rsb_sync #(.WIDTH (1)) wdog_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (watchdog_enable_strap),
        .level  (wdog_sync)
    );

    rsb_sync #(.WIDTH (1)) polarity_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (host_strobe_polarity_strap),
        .level  (polarity_sync)
    );

    rsb_sync #(.WIDTH (1)) width_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (host_width_strap),
        .level  (width_sync)
    );

    rsb_sync #(.WIDTH (1)) style_sync_inst
    (
        .clock  (clock),
        .arst_n (arst_n),
        .pin    (host_strobe_style_strap),
        .level  (style_sync)
    );

    // Previous synchronised power-on level for edge detection
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            por_prev_r <= 1'h0;
        else
            por_prev_r <= por_n;
    end

    // Strap capture; straps are steady during reset so sampling late is safe
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_source             <= `RSB_BOOT_RST;
            watchdog_enable         <= `RSB_WDOG_RST;
            host_strobe_active_high <= `RSB_STROBE_RST;
            host_width_8bit         <= `RSB_WIDTH_RST;
            host_strobe_style       <= `RSB_STROBE_RST;
        end
        else if (por_rise)
        begin
            boot_source             <= boot_sync;
            watchdog_enable         <= wdog_sync;
            host_strobe_active_high <= polarity_sync;
            host_width_8bit         <= width_sync;
            host_strobe_style       <= style_sync;
        end
    end

    // Boot sequencer
    always @*
    begin
        state_nxt   = state_r;
        rom_cnt_nxt = rom_cnt_r;
        case (state_r)
            `RSB_ST_IDLE:
            begin
                rom_cnt_nxt = 4'h0;
                if (!in_reset)
                    state_nxt = `RSB_ST_ROM;
            end
            `RSB_ST_ROM:
            begin
                rom_cnt_nxt = rom_cnt_r + 4'h1;
                if (rom_cnt_r == `RSB_ROM_INIT_CYCLES - 4'h1)
                begin
                    case (boot_source)
                        `RSB_BOOT_HOST_NOPLL: state_nxt = `RSB_ST_HOST;
                        `RSB_BOOT_HOST_PLL:   state_nxt = `RSB_ST_HOST;
                        `RSB_BOOT_TWO_WIRE:   state_nxt = `RSB_ST_TWO_WIRE;
                        default:              state_nxt = `RSB_ST_HALT;
                    endcase
                end
            end
            `RSB_ST_HOST:
            begin
                if (boot_complete)
                    state_nxt = `RSB_ST_DONE;
            end
            `RSB_ST_TWO_WIRE:
            begin
                if (boot_complete)
                    state_nxt = `RSB_ST_DONE;
            end
            `RSB_ST_DONE:
                state_nxt = state_r;
            `RSB_ST_HALT:
                state_nxt = state_r;
            default:
                state_nxt = `RSB_ST_IDLE;
        endcase
        if (in_reset)
            state_nxt = `RSB_ST_IDLE;
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r   <= `RSB_ST_IDLE;
            rom_cnt_r <= 4'h0;
        end
        else
        begin
            state_r   <= state_nxt;
            rom_cnt_r <= rom_cnt_nxt;
        end
    end

    // Bypass PLL until software enables it once the loader has left its ROM stage
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pll_bypass <= 1'h1;
            pll_enable <= 1'h0;
        end
        else if (!por_n)
        begin
            pll_bypass <= 1'h1;
            pll_enable <= 1'h0;
        end
        else if (sw_pll_enable && state_r != `RSB_ST_IDLE && state_r != `RSB_ST_ROM)
        begin
            pll_bypass <= 1'h0;
            pll_enable <= 1'h1;
        end
    end

    // Boot path outputs follow the next state
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rom_loader_run      <= 1'h0;
            host_boot_active    <= 1'h0;
            host_dma_enable     <= 1'h0;
            host_irq_enable     <= 1'h0;
            host_msw_first      <= 1'h0;
            host_bit0_lsb       <= 1'h1;
            two_wire_pin_select <= 1'h0;
            two_wire_master     <= 1'h0;
            boot_reserved_error <= 1'h0;
        end
        else
        begin
            rom_loader_run      <= (state_nxt == `RSB_ST_ROM) |
                                   (state_nxt == `RSB_ST_HOST) |
                                   (state_nxt == `RSB_ST_TWO_WIRE);
            host_boot_active    <= (state_nxt == `RSB_ST_HOST);
            host_dma_enable     <= 1'h0;
            host_irq_enable     <= 1'h0;
            host_msw_first      <= (state_nxt == `RSB_ST_HOST);
            host_bit0_lsb       <= 1'h1;
            two_wire_pin_select <= (state_nxt == `RSB_ST_TWO_WIRE) |
                                   (two_wire_pin_select & ~in_reset);
            two_wire_master     <= (state_nxt == `RSB_ST_TWO_WIRE);
            boot_reserved_error <= (state_nxt == `RSB_ST_HALT);
        end
    end

    // Open-drain drive: only ever pulls low, never drives high
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hard_reset_n_out <= 1'h0;
            hard_reset_n_oe  <= 1'h0;
        end
        else
        begin
            hard_reset_n_out <= 1'h0;
            hard_reset_n_oe  <= hard_reset_req | ~por_n;
        end
    end

endmodule

// Two-flop synchroniser for pins from outside the clock domain
module rsb_sync
#(
    parameter WIDTH = 1
)
(
    input  wire [WIDTH-1:0] pin,
    input  wire             clock,
    input  wire             arst_n,
    output wire [WIDTH-1:0] level
);

    reg [WIDTH-1:0] first_r;
    reg [WIDTH-1:0] second_r;

    assign level = second_r;

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_r  <= {WIDTH{1'h0}};
            second_r <= {WIDTH{1'h0}};
        end
        else
        begin
            first_r  <= pin;
            second_r <= first_r;
        end
    end

endmodule

// ===== shared/rsb_defs.vh
// Constants for the reset strap capture and boot select block
`ifndef RSB_DEFS_VH
`define RSB_DEFS_VH

`define RSB_BOOT_HOST_NOPLL 2'h0
`define RSB_BOOT_TWO_WIRE   2'h1
`define RSB_BOOT_HOST_PLL   2'h2
`define RSB_BOOT_RESERVED   2'h3

`define RSB_BOOT_RST        2'h3
`define RSB_WDOG_RST        1'h0
`define RSB_STROBE_RST      1'h0
`define RSB_WIDTH_RST       1'h0

`define RSB_ST_IDLE         3'h0
`define RSB_ST_ROM          3'h1
`define RSB_ST_HOST         3'h2
`define RSB_ST_TWO_WIRE     3'h3
`define RSB_ST_DONE         3'h4
`define RSB_ST_HALT         3'h5

// Clock cycles spent in the ROM loader stage before a boot path starts
`define RSB_ROM_INIT_CYCLES 4'h8

`endif

// ===== test/rsb_board.sv
// Board model: strap pins, power-on source, pulled-up hard reset line
`timescale 1ns/1ns
module rsb_board
(
    input  wire       clock,
    input  wire       por_req,
    input  wire       hard_pull,
    input  wire       hard_oe,
    input  wire [5:0] cfg,
    output reg        power_on_reset_n,
    output wire       hard_reset_n,
    output wire [5:0] straps
);
    reg [2:0] hold_cnt_r = 3'h0;
    initial power_on_reset_n = 1'h0;
    always @(posedge clock)
    begin
        power_on_reset_n <= ~por_req;
        hold_cnt_r <= por_req ? 3'h0 : hold_cnt_r + {2'h0, hold_cnt_r != 3'h7};
    end
    // Pins float to the inverse once the hold after release ends
    assign straps = (hold_cnt_r == 3'h7) ? ~cfg : cfg;
    // Open drain only: low when pulled, pull-up otherwise
    assign hard_reset_n = ~(hard_pull | hard_oe);
endmodule

// ===== test/rsb_monitor.sv
// Checker for strap capture and boot path outputs
`timescale 1ns/1ns
`include "rsb_defs.vh"
module rsb_monitor
(
    input wire       clock,
    input wire       arst_n,
    input wire       power_on_reset_n,
    input wire [1:0] boot_source_strap,
    input wire       watchdog_enable_strap,
    input wire [1:0] boot_source,
    input wire       watchdog_enable,
    input wire       pll_bypass,
    input wire       pll_enable,
    input wire       rom_loader_run,
    input wire       host_boot_active,
    input wire       host_dma_enable,
    input wire       host_msw_first,
    input wire       two_wire_pin_select,
    input wire       two_wire_master,
    input wire       boot_reserved_error
);
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    chk_boot_capture: assert property ($rose(power_on_reset_n) |-> ##4
        boot_source == $past(boot_source_strap, 4)) else $error("boot code not captured");
    chk_wdog_capture: assert property ($rose(power_on_reset_n) |-> ##4
        watchdog_enable == $past(watchdog_enable_strap, 4)) else $error("watchdog not captured");
    chk_straps_held: assert property (power_on_reset_n && $past(power_on_reset_n, 5)
        |-> $stable(boot_source) && $stable(watchdog_enable)) else $error("captured strap moved");
    chk_rom_bypass: assert property ($rose(power_on_reset_n) |-> ##4
        (pll_bypass && !pll_enable) [*4]) else $error("pll not bypassed in loader");
    chk_pll_late: assert property ($rose(pll_enable) |-> !rom_loader_run
        || host_boot_active || two_wire_master) else $error("pll enabled during loader");
    chk_host_boot: assert property (host_boot_active |-> !host_dma_enable
        && host_msw_first && !boot_source[0]) else $error("host boot setup wrong");
    chk_two_wire: assert property (two_wire_master |-> two_wire_pin_select
        && boot_source == `RSB_BOOT_TWO_WIRE) else $error("two-wire setup wrong");
    chk_reserved_halt: assert property (boot_reserved_error |-> !host_boot_active
        && !two_wire_master && boot_source == `RSB_BOOT_RESERVED) else $error("reserved booted");
endmodule

// ===== test/testbench.sv
// Bench: power-on and hard reset cycles over every boot code
`timescale 1ns/1ns
`include "rsb_defs.vh"
module testbench;
    reg        clock = 1'h0, arst_n = 1'h0, por_req = 1'h1, hard_pull = 1'h0;
    reg        sw_pll_enable = 1'h0, boot_complete = 1'h0, hard_req = 1'h0;
    reg  [5:0] cfg = 6'h00;
    reg  [1:0] b;
    wire [1:0] boot_source_strap, boot_source;
    wire       power_on_reset_n, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe;
    wire       watchdog_enable_strap, host_strobe_polarity_strap, host_width_strap;
    wire       host_strobe_style_strap, watchdog_enable, host_strobe_active_high;
    wire       host_width_8bit, host_strobe_style, pll_bypass, pll_enable, rom_loader_run;
    wire       host_boot_active, host_dma_enable, host_irq_enable, host_msw_first;
    wire       host_bit0_lsb, two_wire_pin_select, two_wire_master, boot_reserved_error;
    integer    n_mismatch = 0, comparisons = 0, i, k;
    initial forever #50 clock = ~clock;
    rsb_board rsb_board_inst (.clock, .por_req, .hard_pull, .hard_oe(hard_reset_n_oe), .cfg,
        .power_on_reset_n, .hard_reset_n(hard_reset_n_in), .straps({boot_source_strap,
        watchdog_enable_strap, host_strobe_polarity_strap, host_width_strap,
        host_strobe_style_strap}));
    rsb_reset_strap_boot_select rsb_reset_strap_boot_select_inst (.clock, .arst_n,
        .power_on_reset_n, .hard_reset_n_in, .hard_reset_req(hard_req), .boot_source_strap,
        .watchdog_enable_strap, .host_strobe_polarity_strap, .host_width_strap,
        .host_strobe_style_strap, .sw_pll_enable, .boot_complete, .hard_reset_n_out,
        .hard_reset_n_oe, .boot_source, .watchdog_enable, .host_strobe_active_high,
        .host_width_8bit, .host_strobe_style, .pll_bypass, .pll_enable, .rom_loader_run,
        .host_boot_active, .host_dma_enable, .host_irq_enable, .host_msw_first,
        .host_bit0_lsb, .two_wire_pin_select, .two_wire_master, .boot_reserved_error);
    task print_verdict;
    begin
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task check(input string name, input [7:0] seen, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // Bounded wait for a boot path, or for the loader to stop
    task wait_path(input reg done);
    begin
        k = 0;
        while (k < 40 && (done ? rom_loader_run !== 1'h0
            : (host_boot_active | two_wire_master | boot_reserved_error) !== 1'h1))
        begin
            @(negedge clock);
            k = k + 1;
        end
        if (k == 40)
        begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
        end
    end
    endtask
    task straps_check;
        check("straps", {2'h0, boot_source, watchdog_enable, host_strobe_active_high,
            host_width_8bit, host_strobe_style}, {2'h0, cfg});
    endtask
    initial
    begin
        repeat (20) @(negedge clock);
        arst_n = 1'h1;
        for (i = 0; i < 4; i = i + 1)
        begin
            b = i;
            sw_pll_enable = 1'h0;
            por_req = 1'h1;
            cfg = {b, b[0] ? 4'hA : 4'h5};
            repeat (5) @(negedge clock);
            check("por_drive", {6'h00, hard_reset_n_oe, hard_reset_n_out}, 8'h02);
            por_req = 1'h0;
            wait_path(1'h0);
            straps_check;
            check("path", {host_boot_active, two_wire_master, boot_reserved_error, pll_bypass,
                pll_enable, host_dma_enable, host_irq_enable, host_bit0_lsb},
                {!b[0], b == 2'h1, b == 2'h3, 5'h11});
            check("msw", {7'h00, host_msw_first}, {7'h00, !b[0]});
            hard_pull = b[0];
            hard_req = !b[0];
            repeat (5) @(negedge clock);
            check("hrst", {6'h00, hard_reset_n_oe, hard_reset_n_out},
                {6'h00, !b[0], 1'h0});
            hard_pull = 1'h0;
            hard_req = 1'h0;
            sw_pll_enable = 1'h1;
            wait_path(1'h0);
            straps_check;
            check("pll_early", {6'h00, pll_bypass, pll_enable}, 8'h02);
            repeat (2) @(negedge clock);
            check("pll", {6'h00, pll_bypass, pll_enable}, 8'h01);
            boot_complete = 1'h1;
            @(negedge clock);
            boot_complete = 1'h0;
            wait_path(1'h1);
            check("done", {host_boot_active, boot_reserved_error, two_wire_pin_select},
                {1'h0, b == 2'h3, b == 2'h1});
        end
        print_verdict;
    end
endmodule
bind rsb_reset_strap_boot_select rsb_monitor rsb_monitor_inst (.clock, .arst_n,
    .power_on_reset_n, .boot_source_strap, .watchdog_enable_strap, .boot_source,
    .watchdog_enable, .pll_bypass, .pll_enable, .rom_loader_run, .host_boot_active,
    .host_dma_enable, .host_msw_first, .two_wire_pin_select, .two_wire_master,
    .boot_reserved_error);
